// >>> design/wlsd_map.svh
// Register offsets, constants, widths and timing counts for the word line select decode block.
`ifndef WLSD_MAP_SVH
`define WLSD_MAP_SVH
`define WLSD_ADDR_W        16
`define WLSD_WORD_W        12
`define WLSD_HALF_W        6
`define WLSD_DIGIT_W       4
`define WLSD_DATA_W        36
`define WLSD_ROWS          8
`define WLSD_PKG_GROUPS    8
`define WLSD_DEC_OUTS      64
`define WLSD_CLK_HZ        50000000
`define WLSD_CARRIER_HZ    10000000
`define WLSD_CARRIER_HALF  ((`WLSD_CLK_HZ / `WLSD_CARRIER_HZ) / 2)
`define WLSD_OP_CYCLES     16
`define WLSD_REG_ADDR      4'h0
`define WLSD_REG_DATA      4'h1
`define WLSD_REG_CMD       4'h2
`define WLSD_REG_STATUS    4'h3
`define WLSD_CMD_READ_BIT  0
`define WLSD_CMD_WRITE_BIT 1
`define WLSD_ST_BUSY_BIT   0
`endif

// >>> design/wlsd_pkg.sv
// Types shared by the word line select decode block.
package wlsd_pkg;
  typedef enum logic [1:0] {
    WLSD_IDLE,
    WLSD_READ,
    WLSD_WRITE
  } wlsd_state_e;

  typedef struct packed {
    logic [7:0] row_pick;
    logic       group_pick_low;
    logic       group_pick_high;
  } wlsd_pkg_sel_s;

  typedef struct packed {
    logic [63:0] decode_a_output;
    logic [63:0] decode_b_output;
  } wlsd_decode_s;
endpackage : wlsd_pkg

// >>> design/wlsd_top.sv
// Word line select decode: interface registers, two-level word decode, carrier and digit drive.
`timescale 1ns/1ps
`include "wlsd_map.svh"

// Summary of operation
// - Three low bits decode to eight row picks
// - Fourth bit picks exactly one group line; here bit 3 feeds decoder A and group-high is never driven
// - Word current needs group, row and carrier
// - Package serves sixteen lines, two groups
// - Spare word outputs stay idle in use
// - Read drives carrier; digit returns double frequency
// - Read bit from phase against reference line
// - Write adds polarity digit pulse per bit
// - Address, command, shared data register
// - Address splits into word and digit fields
// - Two six-bit halves, identical 64 decoders
// - 256 packages, eight groups; first decoder rows
// - Next eight outputs feed next group
// - Second decoder outputs feed group-low inputs
// - Single source gated to exactly one line
// - Carrier routed to decoded word line
// - Digit matrix passes sense and write currents
module wlsd_top #(
  parameter int unsigned DATA_W   = `WLSD_DATA_W,
  parameter int unsigned DIGIT_W  = `WLSD_DIGIT_W,
  parameter int unsigned OP_CYC   = `WLSD_OP_CYCLES
) (
  input  wire logic                i_clk,
  input  wire logic                i_rst_n,
  input  wire logic [3:0]          i_addr,
  input  wire logic [63:0]         i_wdata,
  input  wire logic                i_wr,
  input  wire logic                i_rd,
  output logic      [63:0]         o_rdata,
  input  wire logic [DATA_W-1:0]   i_sense_phase,
  input  wire logic [DATA_W-1:0]   i_ref_phase,
  output wlsd_pkg::wlsd_decode_s   o_decode,
  output logic      [7:0]          o_row_pick_group [8],
  output logic      [63:0]         o_group_pick_low,
  output logic      [63:0]         o_group_pick_high,
  output logic                     o_carrier,
  output logic      [1:0]          o_spare_word_line,
  output logic      [DIGIT_W-1:0]  o_digit_select,
  output logic                     o_digit_sense_en,
  output logic                     o_digit_write_en,
  output logic      [DATA_W-1:0]   o_digit_polarity,
  output logic                     o_busy
);

  localparam int unsigned HALF_CNT = (`WLSD_CARRIER_HALF < 1) ? 1 : `WLSD_CARRIER_HALF;

  logic [`WLSD_ADDR_W-1:0] addr_reg;
  logic [DATA_W-1:0]       data_reg;
  wlsd_pkg::wlsd_state_e   state_reg;
  logic [7:0]              op_cnt_reg;
  logic [7:0]              hf_cnt_reg;
  logic                    carrier_reg;
  logic                    go_rd;
  logic                    go_wr;
  logic [`WLSD_WORD_W-1:0] word_addr;
  logic [DIGIT_W-1:0]      digit_addr;
  logic [63:0]             dec_a;

  // One-hot decode of a six-bit half; both halves share it.
  function automatic logic [63:0] wlsd_dec64(input logic [5:0] a);
    logic [63:0] v;
    v    = 64'h0;
    v[a] = 1'b1;
    return v;
  endfunction : wlsd_dec64

  assign word_addr  = addr_reg[`WLSD_WORD_W-1:0];
  assign digit_addr = addr_reg[`WLSD_WORD_W +: DIGIT_W];
  // A function result cannot be part-selected, so the first decoder lives on a net of its own.
  assign dec_a      = wlsd_dec64(word_addr[5:0]);
  assign go_rd = i_wr && (i_addr == `WLSD_REG_CMD) && i_wdata[`WLSD_CMD_READ_BIT];
  assign go_wr = i_wr && (i_addr == `WLSD_REG_CMD) && i_wdata[`WLSD_CMD_WRITE_BIT] &&
                 !i_wdata[`WLSD_CMD_READ_BIT];

  // Address is locked while busy so the selected line cannot move mid-operation.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      addr_reg <= 16'h0000;
    end else if (i_wr && (i_addr == `WLSD_REG_ADDR) && (state_reg == wlsd_pkg::WLSD_IDLE)) begin
      addr_reg <= i_wdata[`WLSD_ADDR_W-1:0];
    end
  end

  // Shared data register: host writes land here, and read bits overwrite it at the end of a read.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      data_reg <= '0;
    end else if ((state_reg == wlsd_pkg::WLSD_READ) && (op_cnt_reg == 8'h01)) begin
      data_reg <= i_sense_phase ^ i_ref_phase;
    end else if (i_wr && (i_addr == `WLSD_REG_DATA) && (state_reg == wlsd_pkg::WLSD_IDLE)) begin
      data_reg <= i_wdata[DATA_W-1:0];
    end
  end

  // Commands while busy are ignored; read wins if both bits are set.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg  <= wlsd_pkg::WLSD_IDLE;
      op_cnt_reg <= 8'h00;
    end else begin
      case (state_reg)
        wlsd_pkg::WLSD_IDLE: begin
          if (go_rd) begin
            state_reg  <= wlsd_pkg::WLSD_READ;
            op_cnt_reg <= OP_CYC[7:0];
          end else if (go_wr) begin
            state_reg  <= wlsd_pkg::WLSD_WRITE;
            op_cnt_reg <= OP_CYC[7:0];
          end
        end
        wlsd_pkg::WLSD_READ, wlsd_pkg::WLSD_WRITE: begin
          if (op_cnt_reg == 8'h01) begin
            state_reg  <= wlsd_pkg::WLSD_IDLE;
            op_cnt_reg <= 8'h00;
          end else begin
            op_cnt_reg <= op_cnt_reg - 8'h01;
          end
        end
        default: begin
          state_reg  <= wlsd_pkg::WLSD_IDLE;
          op_cnt_reg <= 8'h00;
        end
      endcase
    end
  end

  // Carrier toggles only during an operation; with a 50 MHz clock the half period rounds down to 2 cycles, so 10 MHz comes out as 12.5 MHz.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hf_cnt_reg  <= 8'h00;
      carrier_reg <= 1'b0;
    end else if (state_reg == wlsd_pkg::WLSD_IDLE) begin
      hf_cnt_reg  <= 8'h00;
      carrier_reg <= 1'b0;
    end else if (hf_cnt_reg == HALF_CNT[7:0] - 8'h01) begin
      hf_cnt_reg  <= 8'h00;
      carrier_reg <= ~carrier_reg;
    end else begin
      hf_cnt_reg <= hf_cnt_reg + 8'h01;
    end
  end

  // Selects are registered from the locked address and cleared when idle.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_decode          <= '0;
      o_group_pick_low  <= 64'h0;
      o_group_pick_high <= 64'h0;
      o_carrier         <= 1'b0;
      o_spare_word_line <= 2'h0;
      for (int g = 0; g < `WLSD_PKG_GROUPS; g++) begin
        o_row_pick_group[g] <= 8'h00;
      end
    end else if (state_reg == wlsd_pkg::WLSD_IDLE) begin
      o_decode          <= '0;
      o_group_pick_low  <= 64'h0;
      o_group_pick_high <= 64'h0;
      o_carrier         <= 1'b0;
      o_spare_word_line <= 2'h0;
      for (int g = 0; g < `WLSD_PKG_GROUPS; g++) begin
        o_row_pick_group[g] <= 8'h00;
      end
    end else begin
      o_decode.decode_a_output <= wlsd_dec64(word_addr[5:0]);
      o_decode.decode_b_output <= wlsd_dec64(word_addr[11:6]);
      // Decoder A bits 0..2 are the row address, bit 3..5 pick the package group.
      for (int g = 0; g < `WLSD_PKG_GROUPS; g++) begin
        o_row_pick_group[g] <= dec_a[g*8 +: 8];
      end
      // Decoder B picks exactly one of the 64 group-low inputs across all package groups; group-high stays off.
      o_group_pick_low  <= wlsd_dec64(word_addr[11:6]);
      o_group_pick_high <= 64'h0;
      o_carrier         <= carrier_reg;
      o_spare_word_line <= 2'h0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_digit_select   <= '0;
      o_digit_sense_en <= 1'b0;
      o_digit_write_en <= 1'b0;
      o_digit_polarity <= '0;
      o_busy           <= 1'b0;
    end else begin
      o_digit_select   <= (state_reg == wlsd_pkg::WLSD_IDLE) ? '0 : digit_addr;
      o_digit_sense_en <= (state_reg == wlsd_pkg::WLSD_READ);
      o_digit_write_en <= (state_reg == wlsd_pkg::WLSD_WRITE);
      o_digit_polarity <= (state_reg == wlsd_pkg::WLSD_WRITE) ? data_reg : '0;
      o_busy           <= (state_reg != wlsd_pkg::WLSD_IDLE);
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= 64'h0;
    end else if (i_rd) begin
      case (i_addr)
        `WLSD_REG_ADDR:   o_rdata <= {48'h0, addr_reg};
        `WLSD_REG_DATA:   o_rdata <= {{(64-DATA_W){1'b0}}, data_reg};
        `WLSD_REG_STATUS: o_rdata <= {63'h0, (state_reg != wlsd_pkg::WLSD_IDLE)};
        default:          o_rdata <= 64'h0;
      endcase
    end else begin
      o_rdata <= 64'h0;
    end
  end

endmodule : wlsd_top

// >>> tb/wlsd_top_asserts.sv
// Port checker for the word line select decode block.
`timescale 1ns/1ps
module wlsd_top_asserts #(
  parameter int unsigned OP_CYC = 16
) (
  input wire logic              i_clk,
  input wire logic              i_rst_n,
  input wlsd_pkg::wlsd_decode_s o_decode,
  input wire logic [7:0]        o_row_pick_group [8],
  input wire logic [63:0]       o_group_pick_low,
  input wire logic [63:0]       o_group_pick_high,
  input wire logic              o_carrier,
  input wire logic              o_digit_sense_en,
  input wire logic              o_digit_write_en,
  input wire logic              o_busy
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  logic [7:0]  cnt_reg;
  logic [63:0] rows;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) cnt_reg <= 8'h00;
    else cnt_reg <= o_busy ? cnt_reg + 8'h01 : 8'h00;
  end
  always_comb for (int g = 0; g < 8; g++) rows[g*8 +: 8] = o_row_pick_group[g];
  sequence s_rise; $rose(o_carrier); endsequence
  sequence s_tail; o_carrier ##1 !o_carrier; endsequence
  a_idle_quiet: assert property (!o_busy |-> o_decode == '0 && o_group_pick_low == '0)
    else $error("selects active while idle");
  a_row_onehot: assert property (o_busy |-> $onehot(o_decode.decode_a_output) && $onehot(o_group_pick_low))
    else $error("decode not one-hot");
  a_rows_fanout: assert property (rows == o_decode.decode_a_output)
    else $error("row picks differ from first decoder");
  a_group_fanout: assert property (o_group_pick_low == o_decode.decode_b_output && o_group_pick_high == '0)
    else $error("group picks differ from second decoder");
  a_carrier_gated: assert property (o_carrier |-> o_busy)
    else $error("carrier outside an operation");
  a_carrier_wave: assert property (s_rise |=> s_tail)
    else $error("carrier high time wrong");
  a_op_length: assert property ($fell(o_busy) |-> cnt_reg == OP_CYC)
    else $error("operation length wrong");
  a_drive_excl: assert property (o_busy == (o_digit_sense_en ^ o_digit_write_en))
    else $error("digit drive mode wrong");
endmodule : wlsd_top_asserts
bind wlsd_top wlsd_top_asserts #(.OP_CYC(OP_CYC)) u_chk (.i_clk(i_clk), .i_rst_n(i_rst_n), .o_decode(o_decode),
  .o_row_pick_group(o_row_pick_group), .o_group_pick_low(o_group_pick_low), .o_group_pick_high(o_group_pick_high),
  .o_carrier(o_carrier), .o_digit_sense_en(o_digit_sense_en), .o_digit_write_en(o_digit_write_en), .o_busy(o_busy));

// >>> tb/wlsd_stack_model.sv
// Memory stack model: stores written words and returns digit and reference phases.
`timescale 1ns/1ps
module wlsd_stack_model (
  input  wire logic         i_clk,
  input  wire logic [131:0] i_key,
  input  wire logic         i_wr_en,
  input  wire logic [35:0]  i_pol,
  output logic      [35:0]  o_sense = 36'h0,
  output logic      [35:0]  o_ref = 36'h0
);
  logic [35:0] mem [logic [131:0]];
  logic [35:0] noise;
  // Both lines carry the same fresh noise each cycle, so only a true compare recovers the bit.
  always @(posedge i_clk) begin
    noise = 36'({$urandom(), $urandom()});
    o_sense <= (mem.exists(i_key) ? mem[i_key] : 36'h0) ^ noise;
    o_ref <= noise;
    if (i_wr_en) mem[i_key] = i_pol;
  end
endmodule : wlsd_stack_model

// >>> tb/wlsd_top_test.sv
// Self-checking bench for the word line select decode block.
`timescale 1ns/1ps
module wlsd_top_test;
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, car, sen, wen, busy;
  logic [3:0] addr = 4'h0, dsel;
  logic [63:0] wdata = 64'h0, rv, rdata, gpl, gph;
  logic [35:0] sense, refp, pol;
  logic [7:0] rows [8];
  logic [1:0] spare;
  wlsd_pkg::wlsd_decode_s dec;
  logic [35:0] mdl [logic [15:0]];
  int failures = 0, tests_run = 0, cyc = 0;
  always #10 clk = ~clk;
  wlsd_top uut (.i_clk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .i_sense_phase(sense), .i_ref_phase(refp), .o_decode(dec), .o_row_pick_group(rows),
    .o_group_pick_low(gpl), .o_group_pick_high(gph), .o_carrier(car), .o_spare_word_line(spare),
    .o_digit_select(dsel), .o_digit_sense_en(sen), .o_digit_write_en(wen), .o_digit_polarity(pol), .o_busy(busy));
  wlsd_stack_model stack (.i_clk(clk), .i_key({dec, dsel}), .i_wr_en(wen), .i_pol(pol), .o_sense(sense),
    .o_ref(refp));
  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic conclude();
    $display("Checks run %0d, failed %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : conclude
  // A gap cycle between transfers keeps each strobe to one assignment per time step.
  task automatic bus(input logic w, input logic [3:0] a, input logic [63:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus
  task automatic rdreg(input logic [3:0] a);
    bus(1'b0, a, 64'h0);
    #1 rv = rdata;
  endtask : rdreg
  task automatic op(input logic [15:0] a, input logic [35:0] d, input logic [1:0] c);
    logic [35:0] e;
    e = c[0] ? (mdl.exists(a) ? mdl[a] : 36'h0) : d;
    bus(1'b1, 4'h0, {48'h0, a});
    bus(1'b1, 4'h1, {28'h0, d});
    bus(1'b1, 4'h2, {62'h0, c});
    @(posedge clk);
    #1 chk(dec, {64'h1 << a[5:0], 64'h1 << a[11:6]});
    chk(rows[a[5:3]], 8'h1 << a[2:0]);
    chk(gpl, 64'h1 << a[11:6]);
    chk({gph, spare, dsel, busy}, {66'h0, a[15:12], 1'b1});
    chk({sen, wen, pol}, {c[0], !c[0], c[0] ? 36'h0 : d});
    bus(1'b1, 4'h0, {48'h0, ~a});
    for (int n = 0; n < 30 && rv[0] !== 1'b0; n++) rdreg(4'h3);
    @(posedge clk);
    #1 chk(dec, 0);
    chk({car, busy, spare}, 0);
    rdreg(4'h0);
    chk(rv, {48'h0, a});
    rdreg(4'h1);
    chk(rv, {28'h0, e});
    if (!c[0]) mdl[a] = d;
  endtask : op
  always @(posedge clk) begin
    cyc++;
    if (cyc == 8000) begin
      failures++;
      conclude();
    end
  end
  initial begin
    logic [15:0] pool [4];
    void'($urandom(32'h21eddcb1));
    pool = '{16'h0000, 16'hffff, 16'h5a38, 16'h0000};
    repeat (16) @(posedge clk);
    chk({dec, busy, car, rdata}, 0);
    rst_n <= 1'b1;
    rdreg(4'h7);
    chk(rv, 0);
    for (int i = 0; i < 24; i++) begin
      pool[3] = 16'($urandom());
      rv = 64'h1;
      op(pool[$urandom() % 4], 36'({$urandom(), $urandom()}), 2'($urandom() % 3 + 1));
    end
    rdreg(4'h2);
    chk(rv, 0);
    conclude();
  end
endmodule : wlsd_top_test
